// File: inc/pdtc_pkg.sv
package pdtc_pkg;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int PRESCALE_W       = 8;
  localparam int COUNT_W          = 16;
  localparam int IRQ_LEVELS       = 7;
  localparam logic [7:0]  PRESCALE_RESET = 8'hFF;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] COUNT_TIMEOUT  = 16'h0000;
  localparam logic        GATE_IDLE_N    = 1'b1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FLAG_TO   = 0;
  localparam int FLAG_TC   = 1;
  localparam int FLAG_TG   = 2;
  localparam int FLAG_CMP  = 3;
  localparam int FLAG_ON   = 4;
  localparam int FLAG_GLVL = 5;
  localparam int FLAG_OUT  = 6;
  localparam int FLAG_W    = 7;
  localparam int EVENT_W   = 3;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    PDTC_OUT_DISABLED,
    PDTC_OUT_TOGGLE,
    PDTC_OUT_ZERO,
    PDTC_OUT_ONE
  } pdtc_out_t;

  // Timing of the system-clock divide-by-two source
  localparam int DIV2_COUNT = 2;

endpackage

// File: verilog/pdtc_sync.sv
`timescale 1ns/1ns
module pdtc_sync
  import pdtc_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1Reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Reset to the pin's idle level so no false edge follows reset
      stage1Reg <= RESET_LEVEL;
      syncOut   <= RESET_LEVEL;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule // pdtc_sync

// File: verilog/pdtc_core.sv
`timescale 1ns/1ns
// How it works
// [RULE_01] Eight-bit countdown prescaler, sixteen-bit downcounter, timeout, compare, clock select.
// [RULE_02] Prescaler and counter step on falling edges of their driving clock.
// [RULE_03] Reset presets prescaler to all ones and clears counter.
// [RULE_04] Counter loads preload on first edge after enable and after each timeout.
// [RULE_05] Prescaler with divide-by-256 tap makes one 24-bit counter.
// [RULE_06] Timeout is all sixteen counter bits zero; mode decides its action.
// [RULE_07] Compare value checked against counter continuously; match sets flags.
// [RULE_08] In compare mode a match may change the waveform pin level.
// [RULE_09] First mux picks clock pin or system clock halved; feeds prescaler.
// [RULE_10] Second mux picks selected clock or prescaler output for counter.
// [RULE_11] Seven interrupt request outputs, one per level.
// [RULE_12] Status flags show active conditions; mask bits gate interrupt requests.
// [RULE_13] External clock pin synchronised before use.
// [RULE_14] External clock levels held at least one system clock period.
// [RULE_15] Gate is active low; optionally gates counter and prescaler.
// [RULE_16] Gate pin synchronised before its level is used.
// [RULE_17] Gate levels held at least one system clock period.
// [RULE_18] Output-action field sets waveform pin initial level and transitions.
// [RULE_19] Software changes control only while soft reset bit is clear.
// [RULE_20] Timer enabled when prescaler-run and soft-reset bits both set; running flag.
// [RULE_21] Tap field selects prescaler output driving counter, divide-by-256 included.
module pdtc_core
  import pdtc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  timerClockPin,
  input  wire logic                  gatePin_n,
  input  wire logic                  softResetBit,
  input  wire logic                  prescalerRunBit,
  input  wire logic                  useTimerPin,
  input  wire logic                  usePrescaler,
  input  wire logic [2:0]            prescaleTap,
  input  wire logic                  gateEnable,
  input  wire logic                  compareMode,
  input  wire logic [1:0]            outputActionField,
  input  wire logic [EVENT_W-1:0]    irqMaskBits,
  input  wire logic [2:0]            irqLevel,
  input  wire logic [COUNT_W-1:0]    preloadValue,
  input  wire logic [COUNT_W-1:0]    compareValue,
  input  wire logic [EVENT_W-1:0]    flagClear,
  output logic                       waveformPin,
  output logic [COUNT_W-1:0]         countValue,
  output logic [PRESCALE_W-1:0]      prescaleValue,
  output logic [FLAG_W-1:0]          statusFlags,
  output logic [IRQ_LEVELS-1:0]      irqRequest_n
);

  // ****************************************
  // Functions
  // ****************************************
  // One-hot active-low request for a level; level 0 means no request
  function automatic logic [IRQ_LEVELS-1:0] levelDecode(input logic [2:0] lvl);
    logic [IRQ_LEVELS-1:0] r;
    r = '1;
    if (lvl != 3'h0) begin
      r[lvl - 3'h1] = 1'b0;
    end
    return r;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic pinSync;
  logic gateSync_n;

  pdtc_sync uPinSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (timerClockPin),
    .syncOut (pinSync)
  ); // see [RULE_13] see [RULE_14]

  pdtc_sync #(.RESET_LEVEL(GATE_IDLE_N)) uGateSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (gatePin_n),
    .syncOut (gateSync_n)
  ); // see [RULE_16] see [RULE_17]

  // ****************************************
  // Clock selection
  // ****************************************
  logic div2Reg;
  logic selClk;
  logic selClkPrevReg;
  logic selFall;
  logic [PRESCALE_W-1:0] prescaleReg;
  logic prescaleOutPrevReg;
  logic prescaleOut;
  logic prescaleFall;
  logic cntFall;
  logic enabled;
  logic gateOpen;
  logic running;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div2Reg <= 1'b0;
    end else begin
      div2Reg <= ~div2Reg;
    end
  end

  assign selClk  = useTimerPin ? pinSync : div2Reg; // see [RULE_09]
  assign selFall = selClkPrevReg & ~selClk;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selClkPrevReg <= 1'b0;
    end else begin
      selClkPrevReg <= selClk;
    end
  end

  assign enabled  = softResetBit & prescalerRunBit; // see [RULE_20]
  assign gateOpen = ~gateEnable | ~gateSync_n; // see [RULE_15]
  assign running  = enabled & gateOpen;

  // Prescaler tap: bit n toggles at selected clock / 2^(n+1); tap 7 is /256
  assign prescaleOut  = prescaleReg[prescaleTap]; // see [RULE_21]
  assign prescaleFall = prescaleOutPrevReg & ~prescaleOut;
  // see [RULE_10] see [RULE_05]
  assign cntFall = usePrescaler ? (prescaleFall & running) : (selFall & running);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prescaleReg        <= PRESCALE_RESET; // see [RULE_03]
      prescaleOutPrevReg <= 1'b1;
    end else begin
      if (!enabled) begin
        prescaleReg <= PRESCALE_RESET;
      end else if (selFall && gateOpen) begin
        prescaleReg <= prescaleReg - 8'h01; // see [RULE_02] see [RULE_01]
      end
      prescaleOutPrevReg <= prescaleOut;
    end
  end

  // ****************************************
  // Counter, timeout and compare
  // ****************************************
  logic [COUNT_W-1:0] countReg;
  logic loadedReg;
  logic timeout;
  logic match;

  assign timeout = loadedReg && (countReg == COUNT_TIMEOUT); // see [RULE_06]
  assign match   = loadedReg && (countReg == compareValue); // see [RULE_07]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      countReg  <= COUNT_RESET; // see [RULE_03]
      loadedReg <= 1'b0;
    end else if (!enabled) begin
      loadedReg <= 1'b0;
    end else if (cntFall) begin
      loadedReg <= 1'b1;
      if (!loadedReg || timeout) begin
        countReg <= preloadValue; // see [RULE_04]
      end else begin
        countReg <= countReg - 16'h0001; // see [RULE_02]
      end
    end
  end

  // Edge detect so a held count raises each event only once
  logic timeoutPrevReg;
  logic matchPrevReg;
  logic gatePrevReg_n;
  logic timeoutEv;
  logic matchEv;
  logic gateEv;

  assign timeoutEv = timeout & ~timeoutPrevReg;
  assign matchEv   = match & ~matchPrevReg;
  // Gate negation while gating counts as a gate event
  assign gateEv    = gateEnable & enabled & gateSync_n & ~gatePrevReg_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timeoutPrevReg <= 1'b0;
      matchPrevReg   <= 1'b0;
      gatePrevReg_n  <= 1'b1;
    end else begin
      timeoutPrevReg <= timeout;
      matchPrevReg   <= match;
      gatePrevReg_n  <= gateSync_n;
    end
  end

  // ****************************************
  // Waveform output
  // ****************************************
  logic outEvent;
  assign outEvent = compareMode ? matchEv : timeoutEv; // see [RULE_08]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waveformPin <= 1'b0;
    end else if (!enabled) begin
      // Initial level while disabled: one mode idles low, others high
      waveformPin <= (outputActionField != PDTC_OUT_ONE); // see [RULE_18]
    end else if (outEvent) begin
      case (pdtc_out_t'(outputActionField))
        PDTC_OUT_TOGGLE: waveformPin <= ~waveformPin; // see [RULE_18]
        PDTC_OUT_ZERO:   waveformPin <= 1'b0;
        PDTC_OUT_ONE:    waveformPin <= 1'b1;
        default:         waveformPin <= waveformPin;
      endcase
    end
  end

  // ****************************************
  // Status flags and interrupt requests
  // ****************************************
  logic [EVENT_W-1:0] stickyReg;
  logic [EVENT_W-1:0] eventVec;
  assign eventVec = {gateEv, matchEv, timeoutEv};

  genvar gi;
  generate
    for (gi = 0; gi < EVENT_W; gi++) begin : gSticky
      // Set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stickyReg[gi] <= 1'b0;
        end else if (eventVec[gi]) begin
          stickyReg[gi] <= 1'b1; // see [RULE_12]
        end else if (flagClear[gi]) begin
          stickyReg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  logic cmpFlagReg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmpFlagReg <= 1'b0;
    end else if (matchEv) begin
      cmpFlagReg <= 1'b1; // see [RULE_07]
    end else if (timeoutEv || !enabled) begin
      cmpFlagReg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      statusFlags   <= '0;
      countValue    <= COUNT_RESET;
      prescaleValue <= PRESCALE_RESET;
    end else begin
      statusFlags[FLAG_W-1:FLAG_ON] <= {waveformPin, ~gateSync_n, running}; // see [RULE_20]
      statusFlags[FLAG_CMP]         <= cmpFlagReg;
      statusFlags[EVENT_W-1:0]      <= stickyReg;
      countValue    <= countReg;
      prescaleValue <= prescaleReg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqRequest_n <= '1;
    end else if (|(stickyReg & irqMaskBits)) begin
      irqRequest_n <= levelDecode(irqLevel); // see [RULE_11] see [RULE_12]
    end else begin
      irqRequest_n <= '1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence seqLoad;
    enabled && cntFall && (!loadedReg || timeout);
  endsequence

  AST_LOAD_PRELOAD: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_04]
    seqLoad |=> (countReg == $past(preloadValue)))
    else $error("counter did not take preload");

  AST_DECREMENT: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_02]
    (enabled && cntFall && loadedReg && !timeout) |=> (countReg == $past(countReg) - 16'h0001))
    else $error("counter did not decrement");

  AST_HOLD_NO_EDGE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_10]
    (!cntFall) |=> (countReg == $past(countReg)))
    else $error("counter moved without a clock edge");

  AST_PRESCALE_IDLE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_03]
    !enabled |=> (prescaleReg == PRESCALE_RESET))
    else $error("prescaler not preset while disabled");

  AST_RUNNING_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_20]
    (softResetBit && prescalerRunBit && gateOpen) |=> statusFlags[FLAG_ON])
    else $error("running flag missing");

  AST_TIMEOUT_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_06]
    timeoutEv |=> ##1 statusFlags[FLAG_TO])
    else $error("timeout flag not set");

  AST_MATCH_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_07]
    matchEv |=> ##1 (statusFlags[FLAG_TC] && statusFlags[FLAG_CMP]))
    else $error("compare flags not set");

  AST_TOGGLE: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_08]
    (enabled && outEvent && outputActionField == PDTC_OUT_TOGGLE)
      |=> (waveformPin != $past(waveformPin)))
    else $error("waveform did not toggle");

  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_12]
    ((stickyReg & irqMaskBits) == '0) |=> (irqRequest_n == '1))
    else $error("masked event raised a request");

  AST_GATE_STOPS: assert property (@(posedge clk) disable iff (!reset_n) // see [RULE_15]
    (enabled && gateEnable && gateSync_n)
      |=> (countReg == $past(countReg) && prescaleReg == $past(prescaleReg)))
    else $error("timer stepped while gate negated");

endmodule // pdtc_core

// File: bench/pdtc_ext_source.sv
`timescale 1ns/1ns
// ****************************************
// Outside world: timer clock pin and gate
// ****************************************
module pdtc_ext_source
  import pdtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clockRun,
  input  wire logic [3:0] halfPeriod,
  input  wire logic       gateAssert,
  output logic            timerClockPin,
  output logic            gatePin_n
);
  logic [3:0] tickReg;
  logic [3:0] last;

  // Never under two cycles a level, so the synchroniser cannot miss one
  assign last = (halfPeriod < 4'h2) ? 4'h1 : halfPeriod - 4'h1;

  // Pin clock stands still low outside a run
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickReg       <= 4'h0;
      timerClockPin <= 1'b0;
    end else if (!clockRun) begin
      tickReg       <= 4'h0;
      timerClockPin <= 1'b0;
    end else if (tickReg >= last) begin
      tickReg       <= 4'h0;
      timerClockPin <= ~timerClockPin;
    end else begin
      tickReg <= tickReg + 4'h1;
    end
  end

  // Callers hold a gate level for many cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gatePin_n <= 1'b1;
    end else begin
      gatePin_n <= ~gateAssert;
    end
  end
endmodule // pdtc_ext_source

// File: bench/prescaled_down_timer_core_tb.sv
`timescale 1ns/1ns
module prescaled_down_timer_core_tb
  import pdtc_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  softResetBit = 1'b0;
  logic                  prescalerRunBit = 1'b0;
  logic                  useTimerPin = 1'b0;
  logic                  usePrescaler = 1'b0;
  logic [2:0]            prescaleTap = 3'h0;
  logic                  gateEnable = 1'b0;
  logic                  compareMode = 1'b0;
  logic [1:0]            outputActionField = 2'h0;
  logic [EVENT_W-1:0]    irqMaskBits = 3'h0;
  logic [2:0]            irqLevel = 3'h0;
  logic [COUNT_W-1:0]    preloadValue = 16'h0000;
  logic [COUNT_W-1:0]    compareValue = 16'h0000;
  logic [EVENT_W-1:0]    flagClear = 3'h0;
  logic                  clockRun = 1'b0;
  logic                  gateAssert = 1'b0;
  logic                  timerClockPin;
  logic                  gatePin_n;
  logic                  waveformPin;
  logic [COUNT_W-1:0]    countValue;
  logic [PRESCALE_W-1:0] prescaleValue;
  logic [FLAG_W-1:0]     statusFlags;
  logic [IRQ_LEVELS-1:0] irqRequest_n;
  int                    mismatches = 0;
  int                    tests_run = 0;
  int                    n;
  logic                  w;
  logic [15:0]           c;

  pdtc_core pdtc_core_inst (.clk(clk), .reset_n(reset_n), .timerClockPin(timerClockPin),
    .gatePin_n(gatePin_n), .softResetBit(softResetBit), .prescalerRunBit(prescalerRunBit),
    .useTimerPin(useTimerPin), .usePrescaler(usePrescaler), .prescaleTap(prescaleTap),
    .gateEnable(gateEnable), .compareMode(compareMode), .outputActionField(outputActionField),
    .irqMaskBits(irqMaskBits), .irqLevel(irqLevel), .preloadValue(preloadValue),
    .compareValue(compareValue), .flagClear(flagClear), .waveformPin(waveformPin),
    .countValue(countValue), .prescaleValue(prescaleValue), .statusFlags(statusFlags),
    .irqRequest_n(irqRequest_n));

  pdtc_ext_source pdtc_ext_source_inst (.clk(clk), .reset_n(reset_n), .clockRun(clockRun),
    .halfPeriod(4'h3), .gateAssert(gateAssert), .timerClockPin(timerClockPin),
    .gatePin_n(gatePin_n));

  // ****************************************
  // Shared tasks
  // ****************************************
  initial forever #4 clk = ~clk;

  task finish_test;
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task wait_count(input logic [15:0] v, input int lim);
    for (int i = 0; i < lim && countValue !== v; i++) @(negedge clk);
    check(countValue, v, "count value not reached");
  endtask

  // Cycles between two counter steps, bounded so a stuck counter cannot hang
  task gap(output int k);
    logic [15:0] s;
    s = countValue;
    for (k = 0; k < 2000 && countValue === s; k++) @(negedge clk);
    s = countValue;
    for (k = 0; k < 2000 && countValue === s; k++) @(negedge clk);
  endtask

  // Control fields change only with the timer stopped
  task setup(input logic [15:0] pre, input logic [15:0] cmp, input logic cm,
             input logic [1:0] oa, input logic [2:0] mask);
    @(posedge clk);
    softResetBit <= 1'b0;
    @(posedge clk);
    preloadValue      <= pre;
    compareValue      <= cmp;
    compareMode       <= cm;
    outputActionField <= oa;
    irqMaskBits       <= mask;
    prescalerRunBit   <= 1'b1;
    flagClear         <= 3'h7;
    @(posedge clk);
    flagClear <= 3'h0;
    cyc(3);
  endtask

  task run;
    @(posedge clk);
    softResetBit <= 1'b1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    check(countValue, COUNT_RESET, "counter after reset");
    check(prescaleValue, PRESCALE_RESET, "prescaler after reset");
    check(statusFlags, 16'h0000, "flags after reset");
    check(irqRequest_n, 16'h007F, "requests after reset");
  endtask

  task t_timeout;
    setup(16'h0005, 16'h00FF, 1'b0, PDTC_OUT_TOGGLE, 3'b001);
    @(posedge clk);
    irqLevel        <= 3'h3;
    prescalerRunBit <= 1'b0;
    softResetBit    <= 1'b1;
    cyc(4);
    check(statusFlags[FLAG_ON], 1'b0, "running with one enable half");
    @(posedge clk);
    prescalerRunBit <= 1'b1;
    cyc(2);
    check(statusFlags[FLAG_ON], 1'b1, "running flag");
    w = waveformPin;
    wait_count(16'h0005, 8);
    gap(n);
    check(n, 2, "halved system clock step");
    wait_count(16'h0000, 20);
    cyc(4);
    check(statusFlags[FLAG_TO], 1'b1, "timeout flag");
    check(waveformPin, !w, "toggle on timeout");
    check(irqRequest_n, 16'h007B, "level three request");
    wait_count(16'h0005, 14);
    setup(16'h0005, 16'h00FF, 1'b0, PDTC_OUT_TOGGLE, 3'b000);
    check(irqRequest_n, 16'h007F, "masked request");
  endtask

  task t_compare(input logic [1:0] oa, input logic lvl);
    setup(16'h0008, 16'h0003, 1'b1, oa, 3'b010);
    @(posedge clk);
    irqLevel <= 3'h7;
    cyc(2);
    check(waveformPin, !lvl, "initial pin level");
    run();
    wait_count(16'h0003, 40);
    cyc(4);
    check(statusFlags[FLAG_TC], 1'b1, "match flag");
    check(statusFlags[FLAG_CMP], 1'b1, "compare flag");
    check(waveformPin, lvl, "pin after match");
    check(statusFlags[FLAG_OUT], lvl, "pin level flag");
    check(irqRequest_n, 16'h003F, "level seven request");
  endtask

  task t_taps;
    setup(16'h1000, 16'h0FFF, 1'b0, PDTC_OUT_DISABLED, 3'b000);
    for (int t = 0; t < 8; t += 7) begin
      setup(16'h1000, 16'h0FFF, 1'b0, PDTC_OUT_DISABLED, 3'b000);
      @(posedge clk);
      usePrescaler <= 1'b1;
      prescaleTap  <= t[2:0];
      run();
      gap(n);
      gap(n);
      check(n, 4 << t, "prescaler tap step");
    end
  endtask

  task t_pin;
    setup(16'h0100, 16'h0000, 1'b0, PDTC_OUT_DISABLED, 3'b000);
    @(posedge clk);
    usePrescaler <= 1'b0;
    useTimerPin  <= 1'b1;
    clockRun     <= 1'b1;
    run();
    gap(n);
    gap(n);
    check(n, 6, "pin clock step");
    @(posedge clk);
    clockRun <= 1'b0;
  endtask

  task t_gate;
    setup(16'h0100, 16'h0000, 1'b0, PDTC_OUT_DISABLED, 3'b100);
    @(posedge clk);
    useTimerPin <= 1'b0;
    gateEnable  <= 1'b1;
    gateAssert  <= 1'b1;
    cyc(5);
    check(statusFlags[FLAG_GLVL], 1'b1, "gate level flag");
    run();
    cyc(4);
    check(statusFlags[FLAG_ON], 1'b1, "gate open runs");
    @(posedge clk);
    gateAssert <= 1'b0;
    cyc(6);
    check(statusFlags[FLAG_ON], 1'b0, "gate shut stops");
    check(statusFlags[FLAG_TG], 1'b1, "gate flag");
    c = countValue;
    cyc(10);
    check(countValue, c, "count frozen by gate");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    cyc(2);
    t_reset();
    t_timeout();
    t_compare(PDTC_OUT_ZERO, 1'b0);
    t_compare(PDTC_OUT_ONE, 1'b1);
    t_taps();
    t_pin();
    t_gate();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule // prescaled_down_timer_core_tb
